// [rtl/cctc_pkg.sv]
// Shared constants and types for the capture/compare timer control block.
// Assumes a single core clock domain and a plain register port.
package cctc_pkg;

  // Register data width and register indices on the plain port.
  localparam int CCTC_DW = 16;
  localparam logic [3:0] A_CTRL_LOW = 4'h0;
  localparam logic [3:0] A_CTRL_HIGH = 4'h1;
  localparam logic [3:0] A_CTRL2_HIGH = 4'h2;
  localparam logic [3:0] A_STATUS = 4'h3;
  localparam logic [3:0] A_TMR_LO = 4'h4;
  localparam logic [3:0] A_TMR_HI = 4'h5;
  localparam logic [3:0] A_PER_LO = 4'h6;
  localparam logic [3:0] A_PER_HI = 4'h7;
  localparam logic [3:0] A_BUF_LO = 4'h8;
  localparam logic [3:0] A_BUF_HI = 4'h9;
  localparam logic [3:0] A_IRQ_STAT = 4'ha;
  localparam logic [3:0] A_IRQ_MASK = 4'hb;

  // Implemented-bit masks; all other bits read as zero.
  localparam logic [15:0] CTRL_LOW_MASK = 16'h803f;
  localparam logic [15:0] CTRL_HIGH_MASK = 16'h0f1f;
  localparam logic [15:0] CTRL2_MASK = 16'h001f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] PER_RST = 32'hffffffff;

  // Field positions.
  localparam int B_ENABLE = 15;
  localparam int B_WIDE = 5;
  localparam int B_CAPSEL = 4;
  localparam int MODE_LSB = 0;
  localparam int OPS_LSB = 8;
  localparam int SYNC_LSB = 0;
  localparam int AUX_LSB = 3;
  localparam int ICS_LSB = 0;
  localparam int ST_NE = 0;
  localparam int ST_OV = 1;
  localparam int ST_DIS = 2;

  // Capture mode codes.
  localparam logic [3:0] CAP_EDGE = 4'h0;
  localparam logic [3:0] CAP_RISE = 4'h1;
  localparam logic [3:0] CAP_FALL = 4'h2;
  localparam logic [3:0] CAP_BOTH = 4'h3;
  localparam logic [3:0] CAP_RISE4 = 4'h4;
  localparam logic [3:0] CAP_RISE16 = 4'h5;
  localparam logic [3:0] PRE_LIM4 = 4'h3;
  localparam logic [3:0] PRE_LIM16 = 4'hf;

  // Compare and timer mode codes.
  localparam logic [3:0] CMP_TIMER = 4'h0;
  localparam logic [3:0] CMP_HIGH = 4'h1;
  localparam logic [3:0] CMP_LOW = 4'h2;
  localparam logic [3:0] CMP_TOG = 4'h3;
  localparam logic [3:0] CMP_DUAL = 4'h4;
  localparam logic [3:0] CMP_DUALBUF = 4'h5;
  localparam logic [3:0] CMP_EXT = 4'hf;

  // Auxiliary output codes, postscale limit and source codes.
  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] AUX_ROLL = 2'h1;
  localparam logic [1:0] AUX_SEL2 = 2'h2;
  localparam logic [3:0] OPS_CAP_OVF = 4'h4;
  localparam logic [4:0] SYNC_FREE = 5'h00;
  localparam logic [4:0] SYNC_AUTO = 5'h1f;
  localparam logic [4:0] SYNC_MOD_LO = 5'h01;
  localparam logic [4:0] SYNC_MOD_HI = 5'h04;
  localparam logic [4:0] SYNC_EXT_LO = 5'h09;
  localparam logic [4:0] SYNC_EXT_HI = 5'h15;
  localparam logic [4:0] SYNC_CMP1 = 5'h17;
  localparam logic [2:0] ICS_RSV_A = 3'h2;
  localparam logic [2:0] ICS_RSV_B = 3'h3;
  localparam logic [31:0] TMR_WRAP32 = 32'hffffffff;
  localparam logic [31:0] TMR_WRAP16 = 32'h0000ffff;

  // Interrupt status bits.
  localparam int IRQ_W = 4;
  localparam int IRQ_CAP = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_POST = 2;
  localparam int IRQ_ROLL = 3;

  // Major operating mode, one-hot.
  typedef enum logic [2:0] {
    OP_OFF = 3'b001,
    OP_CMP = 3'b010,
    OP_CAP = 3'b100
  } cctc_op_t;

  // One register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cctc_bus_req_t;

  // Decoded compare/timer configuration for the waveform generator.
  typedef struct packed {
    logic outputs_on;
    logic single_edge;
    logic [1:0] edge_act;
    logic dual_edge;
    logic buffered;
    logic ext_input;
    logic reserved;
  } cctc_cmp_cfg_t;

endpackage

// [rtl/cctc_cap_fifo.sv]
// Capture FIFO holding time stamps until software reads them.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module cctc_cap_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so only powers of two are served.
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("Capture FIFO depth must be a power of two of at least 2.");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cctc_fifo_st_t;

  cctc_fifo_st_t st_reg;
  cctc_fifo_st_t st_next;
  logic do_push;
  logic do_pop;

  // Flags come from the count so full and empty are never ambiguous.
  assign o_ready = st_reg.cnt != (AW + 1)'(DEPTH);
  assign o_valid = st_reg.cnt != '0;
  assign o_data = st_reg.mem[st_reg.rp];
  assign do_push = i_push && o_ready;
  assign do_pop = i_pop && o_valid;

  // Flush wins over a push in the same cycle so stale data never survives.
  always_comb begin
    st_next = st_reg;
    if (i_flush) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end else begin
      if (do_push) begin
        st_next.mem[st_reg.wp] = i_data;
        st_next.wp = st_reg.wp + AW'(1);
      end
      if (do_pop) begin
        st_next.rp = st_reg.rp + AW'(1);
      end
      if (do_push && !do_pop) begin
        st_next.cnt = st_reg.cnt + (AW + 1)'(1);
      end else if (do_pop && !do_push) begin
        st_next.cnt = st_reg.cnt - (AW + 1)'(1);
      end
    end
  end

  // Registered state; the clock enable freezes everything.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// [rtl/cctc_ctrl.sv]
// Control, time base and input capture logic of the capture/compare timer.
// Assumes pins and sibling sync lines are asynchronous to the core clock.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module cctc_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire cctc_pkg::cctc_bus_req_t i_bus,
  output logic [15:0] o_rdata,
  input wire logic [7:0] i_cap_src,
  input wire logic [31:0] i_sync_src,
  input wire logic i_special_trig,
  input wire logic i_cmp_event,
  input wire logic i_cmp_signal,
  output logic o_irq,
  output logic o_aux,
  output logic o_sync_out,
  output cctc_pkg::cctc_cmp_cfg_t o_cmp_cfg
);
  import cctc_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl_low;
    logic [15:0] ctrl_high;
    logic [15:0] ctrl2_high;
    logic cap_dis;
    logic cap_ovf;
    logic [31:0] period;
    logic [31:0] tmr;
    logic [31:0] tmr_view;
    logic [7:0] cap_s1;
    logic [7:0] cap_s2;
    logic cap_prev;
    logic [31:0] sync_s1;
    logic [31:0] sync_s2;
    logic sync_prev;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
    logic irq;
    logic aux;
    logic roll_out;
    cctc_cmp_cfg_t cmp;
  } cctc_state_t;

  cctc_state_t st;
  cctc_state_t nx;

  logic enable;
  logic wide;
  logic capsel;
  logic [3:0] mode;
  logic [3:0] ops;
  logic [4:0] syncsel;
  logic [1:0] auxsel;
  logic [2:0] ics;
  cctc_op_t op;
  logic cap_lvl;
  logic cap_rise;
  logic cap_fall;
  logic cap_hit;
  logic cap_ev;
  logic [3:0] pre_lim;
  logic sync_ok;
  logic sync_lvl;
  logic sync_rst;
  logic [31:0] wrapv;
  logic [31:0] per_v;
  logic roll;
  logic post_src;
  logic post_ev;
  logic ovf_set;
  logic clr;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_push;
  logic fifo_pop;
  logic [31:0] fifo_head;
  logic [IRQ_W-1:0] ev_vec;
  logic [15:0] stat_word;
  logic wr_ctrl_low;

  // Configuration fields as software left them.
  assign enable = st.ctrl_low[B_ENABLE];
  assign wide = st.ctrl_low[B_WIDE];
  assign capsel = st.ctrl_low[B_CAPSEL];
  assign mode = st.ctrl_low[MODE_LSB +: 4];
  assign ops = st.ctrl_high[OPS_LSB +: 4];
  assign syncsel = st.ctrl_high[SYNC_LSB +: 5];
  assign auxsel = st.ctrl2_high[AUX_LSB +: 2];
  assign ics = st.ctrl2_high[ICS_LSB +: 3];

  // Major mode; capture only when the select bit is set.
  assign op = !enable ? OP_OFF : (capsel ? OP_CAP : OP_CMP);

  // Edge detection looks only at the second synchroniser stage.
  assign cap_lvl = st.cap_s2[ics] && ics != ICS_RSV_A && ics != ICS_RSV_B;
  assign cap_rise = cap_lvl && !st.cap_prev;
  assign cap_fall = !cap_lvl && st.cap_prev;
  assign pre_lim = (mode == CAP_RISE16) ? PRE_LIM16 : PRE_LIM4;

  // Event qualification per capture mode; reserved codes never fire.
  assign cap_hit = (mode == CAP_EDGE || mode == CAP_BOTH) ?
                   (cap_rise || cap_fall) :
                   (mode == CAP_RISE) ? cap_rise :
                   (mode == CAP_FALL) ? cap_fall :
                   (mode == CAP_RISE4 || mode == CAP_RISE16) ?
                   (cap_rise && st.pre_cnt == pre_lim) : 1'b0;

  // A set disable bit swallows input events.
  assign cap_ev = op == OP_CAP && !st.cap_dis && cap_hit;
  assign fifo_push = cap_ev && fifo_ready;
  assign ovf_set = cap_ev && !fifo_ready;

  // Sync source: sibling modules, external lines, serial edge detects,
  // logic cells and comparator; reserved codes give no sync.
  assign sync_ok = (syncsel >= SYNC_MOD_LO && syncsel <= SYNC_MOD_HI) ||
                   (syncsel >= SYNC_EXT_LO && syncsel <= SYNC_EXT_HI) ||
                   syncsel == SYNC_CMP1;
  assign sync_lvl = sync_ok && st.sync_s2[syncsel];
  assign sync_rst = sync_lvl && !st.sync_prev;

  // Counter width follows the wide select in every mode.
  assign wrapv = wide ? TMR_WRAP32 : TMR_WRAP16;
  assign per_v = wide ? st.period : {16'h0000, st.period[15:0]};

  // Auto-roll ignores the period; other codes also roll on a match.
  assign roll = enable && (st.tmr == wrapv ||
                (syncsel != SYNC_AUTO && st.tmr == per_v));

  // Postscaler counts captures in capture mode, rollovers otherwise.
  assign post_src = (op == OP_CAP) ? cap_ev : roll;
  assign post_ev = post_src && st.post_cnt == ops;

  // A write that disables or changes width, select or mode flushes.
  assign wr_ctrl_low = i_bus.wr && i_bus.addr == A_CTRL_LOW;
  assign clr = wr_ctrl_low &&
               ((!i_bus.wdata[B_ENABLE] && enable) ||
                i_bus.wdata[B_WIDE:0] != st.ctrl_low[B_WIDE:0]);

  assign fifo_pop = i_bus.rd && i_bus.addr == A_BUF_HI;
  assign ev_vec = {roll, post_ev, ovf_set, cap_ev};
  assign stat_word = (16'(st.cap_dis) << ST_DIS) |
                     (16'(st.cap_ovf) << ST_OV) |
                     (16'(fifo_valid) << ST_NE);

  // Capture buffer; a read of the high half retires the oldest entry.
  cctc_cap_fifo #(
    .W(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_flush(clr),
    .i_push(fifo_push),
    .i_data(st.tmr),
    .i_pop(fifo_pop),
    .o_ready(fifo_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_head)
  );

  // Next-state logic for every register of the block.
  always_comb begin
    nx = st;
    nx.cap_s1 = i_cap_src;
    nx.cap_s2 = st.cap_s1;
    nx.cap_prev = cap_lvl;
    nx.sync_s1 = i_sync_src;
    nx.sync_s2 = st.sync_s1;
    nx.sync_prev = sync_lvl;
    // The readable copy lags the live count by one cycle.
    nx.tmr_view = st.tmr;
    nx.roll_out = roll;
    nx.rdata = 16'h0000;

    // Up counter, cleared by disable, flush, sync input or rollover.
    if (clr || !enable || sync_rst || roll) begin
      nx.tmr = 32'h0;
    end else begin
      nx.tmr = (st.tmr + 32'h1) & wrapv;
    end

    // Prescaler for the every-fourth and every-sixteenth modes.
    if (clr || op != OP_CAP) begin
      nx.pre_cnt = 4'h0;
    end else if (cap_rise && !st.cap_dis) begin
      nx.pre_cnt = (st.pre_cnt == pre_lim) ? 4'h0 : st.pre_cnt + 4'h1;
    end

    // Interrupt every ops+1 source events.
    if (clr) begin
      nx.post_cnt = 4'h0;
    end else if (post_src) begin
      nx.post_cnt = post_ev ? 4'h0 : st.post_cnt + 4'h1;
    end

    // Register writes; address decode by priority chain.
    if (i_bus.wr) begin
      if (i_bus.addr == A_CTRL_LOW) begin
        nx.ctrl_low = i_bus.wdata & CTRL_LOW_MASK;
      end else if (i_bus.addr == A_CTRL_HIGH) begin
        nx.ctrl_high = i_bus.wdata & CTRL_HIGH_MASK;
      end else if (i_bus.addr == A_CTRL2_HIGH) begin
        nx.ctrl2_high = i_bus.wdata & CTRL2_MASK;
      end else if (i_bus.addr == A_STATUS) begin
        nx.cap_dis = i_bus.wdata[ST_DIS];
        if (!i_bus.wdata[ST_OV]) begin
          nx.cap_ovf = 1'b0;
        end
      end else if (i_bus.addr == A_PER_LO) begin
        nx.period[15:0] = i_bus.wdata;
      end else if (i_bus.addr == A_PER_HI) begin
        nx.period[31:16] = i_bus.wdata;
      end else if (i_bus.addr == A_IRQ_MASK) begin
        nx.irq_mask = i_bus.wdata[IRQ_W-1:0];
      end
    end
    // A new overflow beats a software clear in the same cycle.
    if (ovf_set) begin
      nx.cap_ovf = 1'b1;
    end

    // Register reads; data is presented in the following cycle only.
    if (i_bus.rd) begin
      if (i_bus.addr == A_CTRL_LOW) begin
        nx.rdata = st.ctrl_low;
      end else if (i_bus.addr == A_CTRL_HIGH) begin
        nx.rdata = st.ctrl_high;
      end else if (i_bus.addr == A_CTRL2_HIGH) begin
        nx.rdata = st.ctrl2_high;
      end else if (i_bus.addr == A_STATUS) begin
        nx.rdata = stat_word;
      end else if (i_bus.addr == A_TMR_LO) begin
        nx.rdata = st.tmr_view[15:0];
      end else if (i_bus.addr == A_TMR_HI) begin
        nx.rdata = st.tmr_view[31:16];
      end else if (i_bus.addr == A_PER_LO) begin
        nx.rdata = st.period[15:0];
      end else if (i_bus.addr == A_PER_HI) begin
        nx.rdata = st.period[31:16];
      end else if (i_bus.addr == A_BUF_LO) begin
        nx.rdata = fifo_head[15:0];
      end else if (i_bus.addr == A_BUF_HI) begin
        nx.rdata = fifo_head[31:16];
      end else if (i_bus.addr == A_IRQ_STAT) begin
        nx.rdata = 16'(st.irq_stat);
      end else if (i_bus.addr == A_IRQ_MASK) begin
        nx.rdata = 16'(st.irq_mask);
      end
    end

    // Sticky events; a read clears them but a same-cycle event survives.
    if (i_bus.rd && i_bus.addr == A_IRQ_STAT) begin
      nx.irq_stat = ev_vec;
    end else begin
      nx.irq_stat = st.irq_stat | ev_vec;
    end
    nx.irq = |(nx.irq_stat & nx.irq_mask);

    // Auxiliary output selection by code and mode.
    case (auxsel)
      AUX_OFF: nx.aux = 1'b0;
      AUX_ROLL: nx.aux = roll;
      default: begin
        case (op)
          OP_CAP: nx.aux = (auxsel == AUX_SEL2) ? st.cap_dis : cap_ev;
          OP_CMP: begin
            if (mode == CMP_TIMER) begin
              nx.aux = (auxsel == AUX_SEL2) ? i_special_trig : 1'b0;
            end else begin
              nx.aux = (auxsel == AUX_SEL2) ? i_cmp_event : i_cmp_signal;
            end
          end
          default: nx.aux = 1'b0;
        endcase
      end
    endcase

    // Compare/timer mode decode for the waveform generator.
    nx.cmp = '0;
    if (op == OP_CMP) begin
      case (mode)
        CMP_TIMER: nx.cmp.outputs_on = 1'b0;
        CMP_HIGH, CMP_LOW, CMP_TOG: begin
          nx.cmp.outputs_on = 1'b1;
          nx.cmp.single_edge = 1'b1;
          nx.cmp.edge_act = mode[1:0];
        end
        CMP_DUAL: begin
          nx.cmp.outputs_on = 1'b1;
          nx.cmp.dual_edge = 1'b1;
        end
        CMP_DUALBUF: begin
          nx.cmp.outputs_on = 1'b1;
          nx.cmp.dual_edge = 1'b1;
          nx.cmp.buffered = 1'b1;
        end
        CMP_EXT: nx.cmp.ext_input = 1'b1;
        default: nx.cmp.reserved = 1'b1;
      endcase
    end
  end

  // State register; a low clock enable freezes the whole block.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st <= '0;
      st.ctrl_low <= CTRL_RST;
      st.ctrl_high <= CTRL_RST;
      st.ctrl2_high <= CTRL_RST;
      st.period <= PER_RST;
    end else if (i_ce) begin
      st <= nx;
    end
  end

  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_aux = st.aux;
  assign o_sync_out = st.roll_out;
  assign o_cmp_cfg = st.cmp;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_cap_blocked;
    i_ce && cap_ev && !fifo_ready;
  endsequence
  sequence s_flush;
    i_ce && clr;
  endsequence

  chk_cap_push_entry: assert property (
    i_ce && cap_ev && fifo_ready && !clr |=> fifo_valid)
    else $error("Capture event did not reach the FIFO.");
  chk_capsel_gate: assert property (
    cap_ev |-> capsel && enable)
    else $error("Capture event outside capture mode.");
  chk_rise_mode_edge: assert property (
    cap_ev && mode == CAP_RISE |-> cap_lvl && !st.cap_prev)
    else $error("Rising mode captured a non-rising edge.");
  chk_narrow_timer: assert property (
    !wide |-> st.tmr[31:16] == 16'h0000)
    else $error("Narrow time base exceeded 16 bits.");
  chk_timer_outputs_off: assert property (
    i_ce && op == OP_CMP && mode == CMP_TIMER |=> !o_cmp_cfg.outputs_on)
    else $error("Timer mode enabled compare outputs.");
  chk_aux_disabled: assert property (
    i_ce && auxsel == AUX_OFF |=> !o_aux)
    else $error("Auxiliary output active while disabled.");
  chk_aux_cap_disable: assert property (
    i_ce && op == OP_CAP && auxsel == AUX_SEL2 |=>
    o_aux == $past(st.cap_dis))
    else $error("Auxiliary output does not mirror capture disable.");
  chk_postscale_count: assert property (
    i_ce && post_ev |=> st.irq_stat[IRQ_POST] && st.post_cnt == 4'h0)
    else $error("Postscaled interrupt at wrong count.");
  chk_auto_rollover: assert property (
    i_ce && enable && syncsel == SYNC_AUTO && st.tmr == per_v &&
    per_v != wrapv && !clr |=> st.tmr == $past(st.tmr) + 32'h1)
    else $error("Auto-rollover restarted at the period.");
  chk_disable_blocks: assert property (
    i_ce && st.cap_dis && !clr && !fifo_pop |=> $stable(fifo_valid))
    else $error("Capture event while capture disabled.");
  chk_overflow_flag: assert property (
    s_cap_blocked |=> st.cap_ovf)
    else $error("Overflow not flagged on full FIFO.");
  chk_flush_clears: assert property (
    s_flush |=> st.tmr == 32'h0 && !fifo_valid)
    else $error("Mode change left timer or FIFO state.");
endmodule

// [verif/cctc_pins_model.sv]
// Behavioural model of the capture input pins beside the timer block.
// Assumes the bench calls run() from its own process on the core clock.
`timescale 1ns/1ps
module cctc_pins_model (
  input wire logic i_core_clk,
  output logic [7:0] o_cap_src
);
  initial o_cap_src = 8'h00;

  // Square wave on line 0; unselected lines take random values so stale levels never help.
  task automatic run(input int periods, input int half);
    repeat (2 * periods) begin
      repeat (half) @(posedge i_core_clk);
      o_cap_src <= {7'($urandom), ~o_cap_src[0]};
    end
  endtask
endmodule

// [verif/cctc_ctrl_tb.sv]
// Self-checking bench for the capture/compare timer control block.
// Assumes the pin model file is compiled first; one 200 MHz clock.
`timescale 1ns/1ps
module cctc_ctrl_tb;
  import cctc_pkg::*;
  logic i_core_clk, i_rstn, i_special_trig, i_cmp_event, i_cmp_signal;
  logic [31:0] i_sync_src;
  cctc_bus_req_t bus;
  logic [15:0] o_rdata, last_rd, t0;
  logic [7:0] cap_src;
  logic [16:0] note;
  logic o_irq, o_aux, o_sync_out, rd_d, ce, sync_pin;
  cctc_cmp_cfg_t o_cmp_cfg;
  logic [16:0] notes[$];
  int bad_count, comparisons, cyc, p, n_aux, n_sync;
  int cap_per[6] = '{2, 3, 3, 2, 12, 48};
  int cap_dif[6] = '{4, 8, 8, 4, 32, 128};
  logic [3:0] cm[6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hf, 4'h6};
  int cb[6] = '{7, 6, 3, 2, 1, 0};

  cctc_ctrl #(.FIFO_DEPTH(4)) cctc_ctrl_i (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_ce(ce), .i_bus(bus), .o_rdata(o_rdata),
    .i_cap_src(cap_src), .i_sync_src(i_sync_src),
    .i_special_trig(i_special_trig), .i_cmp_event(i_cmp_event),
    .i_cmp_signal(i_cmp_signal), .o_irq(o_irq), .o_aux(o_aux),
    .o_sync_out(o_sync_out), .o_cmp_cfg(o_cmp_cfg));
  cctc_pins_model cctc_pins_model_i (.i_core_clk(i_core_clk),
    .o_cap_src(cap_src));

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t output %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
  endtask

  // The read note is taken by the monitor; chk low only records the data.
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic c);
    notes.push_back({c, e});
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  always @(posedge i_core_clk) begin
    if (rd_d) begin
      last_rd = o_rdata;
      note = notes.pop_front();
      if (note[16]) cmp16(o_rdata, note[15:0]);
    end
    rd_d <= bus.rd;
    // Random sync noise on every line except the one the bench owns.
    i_sync_src <= ($urandom & 32'hff7fffff) | (32'(sync_pin) << 23);
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    {i_rstn, i_special_trig, i_cmp_event, i_cmp_signal, rd_d, sync_pin} = '0;
    ce = 1'b1;
    bus = '0;
    i_sync_src = 32'h00000000;
    void'($urandom(32'ha721));
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd(A_CTRL_LOW, 16'h0000, 1);
    rd(A_PER_LO, 16'hffff, 1);
    rd(A_PER_HI, 16'hffff, 1);
    rd(A_STATUS, 16'h0000, 1);
    wr(4'hd, 16'($urandom));
    rd(4'hd, 16'h0000, 1);
    // Each capture mode: entry spacing must match the selected edge kind.
    for (int m = 0; m < 6; m++) begin
      wr(A_CTRL_LOW, 16'h0000);
      wr(A_CTRL_LOW, 16'h8010 | 16'(m));
      cctc_pins_model_i.run(cap_per[m], 4);
      tick(6);
      rd(A_BUF_LO, 16'h0000, 0);
      t0 = last_rd;
      rd(A_BUF_HI, 16'h0000, 1);
      rd(A_BUF_LO, 16'h0000, 0);
      cmp16(last_rd - t0, 16'(cap_dif[m]));
      rd(A_BUF_HI, 16'h0000, 1);
    end
    // Six captures into a four-deep buffer must flag overflow.
    wr(A_CTRL_LOW, 16'h0000);
    rd(A_IRQ_STAT, 16'h0000, 0);
    wr(A_CTRL_LOW, 16'h8013);
    cctc_pins_model_i.run(3, 4);
    tick(6);
    rd(A_STATUS, 16'h0003, 1);
    rd(A_IRQ_STAT, 16'h0007, 1);
    wr(A_STATUS, 16'h0000);
    rd(A_STATUS, 16'h0001, 1);
    // Postscale 1 in wide capture mode: only the second capture interrupts.
    wr(A_CTRL_LOW, 16'h8031);
    wr(A_CTRL_HIGH, 16'h0100);
    for (int j = 0; j < 2; j++) begin
      cctc_pins_model_i.run(1, 4);
      tick(6);
      rd(A_IRQ_STAT, j ? 16'h0005 : 16'h0001, 1);
    end
    wr(A_CTRL_LOW, 16'h8011);
    rd(A_STATUS, 16'h0000, 1);
    wr(A_STATUS, 16'h0004);
    wr(A_CTRL2_HIGH, 16'h0010);
    tick(3);
    cmp1(o_aux, 1'b1);
    cctc_pins_model_i.run(2, 4);
    tick(6);
    rd(A_STATUS, 16'h0004, 1);
    wr(A_STATUS, 16'h0000);
    // Compare modes decode, and pin edges no longer capture.
    for (int k = 0; k < 6; k++) begin
      wr(A_CTRL_LOW, 16'h8000 | 16'(cm[k]));
      tick(3);
      cmp1(o_cmp_cfg[cb[k]], k != 0);
    end
    cctc_pins_model_i.run(2, 4);
    tick(6);
    rd(A_STATUS, 16'h0000, 1);
    // Timer rollover on a random period drives aux, sync out and irq.
    p = 3 + $urandom % 8;
    wr(A_PER_LO, 16'(p - 1));
    wr(A_PER_HI, 16'h0000);
    wr(A_CTRL2_HIGH, 16'h0008);
    wr(A_CTRL_LOW, 16'h8000);
    tick(4);
    {n_aux, n_sync} = '0;
    repeat (10 * p) begin
      @(negedge i_core_clk);
      n_aux += o_aux;
      n_sync += o_sync_out;
    end
    cmp16(16'(n_aux), 16'd10);
    cmp16(16'(n_sync), 16'd10);
    // Auto-roll ignores the short period, so the window sees no rollover.
    wr(A_CTRL_HIGH, 16'h001f);
    tick(4);
    n_aux = 0;
    repeat (10 * p) begin
      @(negedge i_core_clk);
      n_aux += o_aux;
    end
    cmp16(16'(n_aux), 16'd0);
    wr(A_IRQ_MASK, 16'h0008);
    tick(3);
    cmp1(o_irq, 1'b1);
    wr(A_IRQ_MASK, 16'h0000);
    tick(3);
    cmp1(o_irq, 1'b0);
    // A rising comparator sync restarts the count; five frozen cycles of
    // clock enable hold it, so the lagged view still shows four.
    wr(A_PER_LO, 16'hffff);
    wr(A_CTRL_HIGH, 16'h0017);
    @(posedge i_core_clk);
    sync_pin <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    ce <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    ce <= 1'b1;
    rd(A_TMR_LO, 16'h0004, 1);
    i_special_trig <= 1'b1;
    wr(A_CTRL2_HIGH, 16'h0010);
    tick(3);
    cmp1(o_aux, 1'b1);
    wr(A_CTRL2_HIGH, 16'h0000);
    tick(3);
    cmp1(o_aux, 1'b0);
    i_cmp_signal <= 1'b1;
    wr(A_CTRL_LOW, 16'h8003);
    wr(A_CTRL2_HIGH, 16'h0018);
    tick(3);
    cmp1(o_aux, 1'b1);
    wr(A_CTRL2_HIGH, 16'h0010);
    tick(3);
    cmp1(o_aux, 1'b0);
    wr(A_CTRL_LOW, 16'h0000);
    rd(A_IRQ_STAT, 16'h0000, 0);
    rd(A_IRQ_STAT, 16'h0000, 1);
    wrap_up();
  end
endmodule
